// file: rtl/ucb_bridge.sv
// Serial command bridge to a CAN controller, with status lamps.
// Assumes byte-wide UART ports and a frame-level CAN controller.
`timescale 1ns/1ps
`default_nettype none
module ucb_bridge
  import ucb_pkg::*;
#(
  parameter int FIFO_DEPTH = RX_FIFO_DEPTH,
  parameter int BITRATE    = CAN_BITRATE_BPS
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Serial receive byte
  input  wire logic        rx_valid_in,
  input  wire logic [7:0]  rx_data_in,
  // Serial transmit byte
  input  wire logic        tx_ready_in,
  output logic             tx_valid_out,
  output logic [7:0]       tx_data_out,
  // CAN transmit frame
  input  wire logic        can_tx_ready_in,
  input  wire logic        can_tx_done_in,
  output logic             can_tx_valid_out,
  output logic [10:0]      can_tx_id_out,
  output logic [3:0]       can_tx_dlc_out,
  output logic [63:0]      can_tx_data_out,
  // CAN receive frame and status
  input  wire logic        can_rx_valid_in,
  input  wire logic [10:0] can_rx_id_in,
  input  wire logic [3:0]  can_rx_dlc_in,
  input  wire logic [63:0] can_rx_data_in,
  input  wire logic        can_error_in,
  output logic [19:0]      can_bitrate_out,
  output logic             bridge_mode_out,
  // Lamps
  output logic             serial_rx_lamp_out,
  output logic             serial_tx_lamp_out,
  output logic             can_rx_lamp_out,
  output logic             can_tx_lamp_out
);
  localparam int AW = $clog2(FIFO_DEPTH);

  ucb_pstate_t  ps_ff;
  logic         bridge_ff;
  logic [4:0]   cnt_ff;
  logic [11:0]  id_ff;
  logic [63:0]  dat_ff;
  logic         tx_valid_ff;
  logic [7:0]   tx_data_ff;
  logic [7:0]   test_ch_ff;
  logic         ctv_ff;
  logic [10:0]  ct_id_ff;
  logic [3:0]   ct_dlc_ff;
  logic [63:0]  ct_dat_ff;
  logic [19:0]  rate_ff;
  logic [3:0]   lamp_ff;

  // Character classification
  logic        is_hex;
  logic [3:0]  nib;
  logic [3:0]  pairs;
  logic [63:0] aligned;
  logic        z_ok;
  always_comb begin
    is_hex = 1'b0;
    nib    = 4'h0;
    if (rx_data_in >= 8'h30 && rx_data_in <= 8'h39) begin
      is_hex = 1'b1;
      nib    = rx_data_in[3:0];
    end else if (rx_data_in >= 8'h41 && rx_data_in <= 8'h46) begin
      is_hex = 1'b1;
      nib    = rx_data_in[3:0] + 4'h9;
    end
  end
  assign pairs   = cnt_ff[4:1];
  assign aligned = (cnt_ff[0] ? (dat_ff >> 4) : dat_ff)
                   << (7'd64 - {pairs, 3'b000});
  assign z_ok    = rx_valid_in && bridge_ff && ps_ff == PS_DATA
                   && rx_data_in == CH_Z;

  // Mode: test stream until z
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bridge_ff <= 1'b0;
    end else if (rx_valid_in && rx_data_in == CH_Z) begin
      bridge_ff <= 1'b1;
    end
  end

  // Command parser
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ps_ff  <= PS_IDLE;
      cnt_ff <= 5'h00;
      id_ff  <= 12'h000;
      dat_ff <= 64'h0;
    end else if (rx_valid_in && bridge_ff) begin
      unique case (ps_ff)
        PS_IDLE: begin
          if (rx_data_in == CH_I) begin
            ps_ff  <= PS_ID;
            cnt_ff <= 5'h00;
          end
        end
        PS_ID: begin
          if (is_hex) begin
            id_ff  <= {id_ff[7:0], nib};
            cnt_ff <= cnt_ff + 5'h01;
            if (cnt_ff == ID_LAST_DIGIT) begin
              ps_ff <= PS_WAIT_D;
            end
          end else begin
            ps_ff <= PS_IDLE;
          end
        end
        PS_WAIT_D: begin
          ps_ff  <= (rx_data_in == CH_D) ? PS_DATA : PS_IDLE;
          cnt_ff <= 5'h00;
          dat_ff <= 64'h0;
        end
        PS_DATA: begin
          if (rx_data_in == CH_Z) begin
            ps_ff <= PS_IDLE;
          end else if (is_hex && cnt_ff < 5'(2 * MAX_BYTES)) begin
            dat_ff <= {dat_ff[59:0], nib};
            cnt_ff <= cnt_ff + 5'h01;
          end else begin
            ps_ff <= PS_IDLE;
          end
        end
      endcase
    end
  end

  // CAN frame launch; a z while the last frame waits is dropped
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctv_ff    <= 1'b0;
      ct_id_ff  <= 11'h000;
      ct_dlc_ff <= 4'h0;
      ct_dat_ff <= 64'h0;
      rate_ff   <= 20'h00000;
    end else begin
      rate_ff <= 20'(BITRATE);
      if (z_ok && (!ctv_ff || can_tx_ready_in)) begin
        ctv_ff    <= 1'b1;
        ct_id_ff  <= id_ff[10:0];
        ct_dlc_ff <= pairs;
        ct_dat_ff <= aligned;
      end else if (can_tx_ready_in) begin
        ctv_ff <= 1'b0;
      end
    end
  end

  // Receive frame queue
  logic [78:0]  fifo_mem [FIFO_DEPTH];
  logic [AW:0]  wp_ff;
  logic [AW:0]  rp_ff;
  logic         ovf_ff;
  logic         fm_busy_ff;
  logic         fm_warn_ff;
  logic [4:0]   fm_idx_ff;
  logic [78:0]  fm_ent_ff;
  logic         full;
  logic         empty;
  logic         slot;
  logic         start;
  logic         pop;
  assign full  = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
  assign empty = (wp_ff == rp_ff);
  assign slot  = !tx_valid_ff || tx_ready_in;
  assign start = bridge_ff && !fm_busy_ff && (ovf_ff || !empty);
  assign pop   = start && !ovf_ff;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      ovf_ff <= 1'b0;
    end else begin
      if (can_rx_valid_in && !full) begin
        fifo_mem[wp_ff[AW-1:0]] <= {can_rx_id_in, can_rx_dlc_in,
                                    can_rx_data_in};
        wp_ff <= wp_ff + {{AW{1'b0}}, 1'b1};
      end
      if (pop) begin
        rp_ff <= rp_ff + {{AW{1'b0}}, 1'b1};
      end
      // Set wins over the clear by the formatter
      if (can_rx_valid_in && full) begin
        ovf_ff <= 1'b1;
      end else if (start && ovf_ff) begin
        ovf_ff <= 1'b0;
      end
    end
  end

  // Text character for the current index
  logic [7:0]  fm_ch;
  logic [4:0]  fm_last;
  always_comb begin
    logic [3:0]  n;
    logic [63:0] sh;
    logic [4:0]  j;
    n  = 4'h0;
    sh = 64'h0;
    j  = fm_idx_ff - DATA_START;
    fm_last = DATA_START + {fm_ent_ff[67:64], 1'b0} + 5'h01;
    fm_ch   = 8'h20;
    if (fm_warn_ff) begin
      fm_last = WARN_LAST;
      unique case (fm_idx_ff[2:0])
        3'h0:    fm_ch = 8'h4f;
        3'h1:    fm_ch = 8'h56;
        3'h2:    fm_ch = 8'h46;
        3'h3:    fm_ch = CH_CR;
        default: fm_ch = CH_LF;
      endcase
    end else begin
      // Id nibbles, MSB first; 11-bit id padded to 12
      if (fm_idx_ff >= 5'h03 && fm_idx_ff <= 5'h05) begin
        sh = 64'({1'b0, fm_ent_ff[78:68]}) >> (4 * (5 - fm_idx_ff));
        n  = sh[3:0];
      end else begin
        sh = fm_ent_ff[63:0] >> (60 - 4 * j);
        n  = sh[3:0];
      end
      unique case (fm_idx_ff)
        5'h00: fm_ch = 8'h49;
        5'h01: fm_ch = 8'h44;
        5'h02: fm_ch = 8'h3d;
        5'h07: fm_ch = 8'h44;
        5'h08: fm_ch = 8'h61;
        5'h09: fm_ch = 8'h74;
        5'h0a: fm_ch = 8'h61;
        5'h0b: fm_ch = 8'h3d;
        5'h06: fm_ch = 8'h20;
        default: begin
          if (fm_idx_ff == fm_last - 5'h01) begin
            fm_ch = CH_CR;
          end else if (fm_idx_ff == fm_last) begin
            fm_ch = CH_LF;
          end else begin
            fm_ch = (n < 4'ha) ? (8'h30 + 8'(n)) : (8'h37 + 8'(n));
          end
        end
      endcase
    end
  end

  // Serial transmit: test stream or report text
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tx_valid_ff <= 1'b0;
      tx_data_ff  <= 8'h00;
      test_ch_ff  <= TEST_FIRST;
      fm_busy_ff  <= 1'b0;
      fm_warn_ff  <= 1'b0;
      fm_idx_ff   <= 5'h00;
      fm_ent_ff   <= '0;
    end else begin
      if (start) begin
        fm_busy_ff <= 1'b1;
        fm_warn_ff <= ovf_ff;
        fm_idx_ff  <= 5'h00;
        if (!ovf_ff) begin
          fm_ent_ff <= fifo_mem[rp_ff[AW-1:0]];
        end
      end
      if (slot) begin
        tx_valid_ff <= 1'b0;
        if (!bridge_ff) begin
          tx_valid_ff <= 1'b1;
          tx_data_ff  <= test_ch_ff;
          test_ch_ff  <= (test_ch_ff == TEST_LAST) ? TEST_FIRST
                         : test_ch_ff + 8'h01;
        end else if (fm_busy_ff) begin
          tx_valid_ff <= 1'b1;
          tx_data_ff  <= fm_ch;
          fm_idx_ff   <= fm_idx_ff + 5'h01;
          if (fm_idx_ff == fm_last) begin
            fm_busy_ff <= 1'b0;
          end
        end
      end
    end
  end

  // Lamps stretched so a one-cycle event stays visible
  logic [3:0] ev;
  assign ev = {can_tx_done_in, can_rx_valid_in,
               tx_valid_ff && tx_ready_in,
               rx_valid_in};
  for (genvar k = 0; k < 4; k++) begin : g_lamp
    logic [3:0] hold_ff;
    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        hold_ff    <= 4'h0;
        lamp_ff[k] <= 1'b0;
      end else begin
        hold_ff    <= ev[k] ? 4'(LAMP_HOLD) :
                      (hold_ff != 4'h0) ? hold_ff - 4'h1 : 4'h0;
        lamp_ff[k] <= can_error_in || ev[k] || hold_ff > 4'h1;
      end
    end
  end

  assign tx_valid_out       = tx_valid_ff;
  assign tx_data_out        = tx_data_ff;
  assign can_tx_valid_out   = ctv_ff;
  assign can_tx_id_out      = ct_id_ff;
  assign can_tx_dlc_out     = ct_dlc_ff;
  assign can_tx_data_out    = ct_dat_ff;
  assign can_bitrate_out    = rate_ff;
  assign bridge_mode_out    = bridge_ff;
  assign serial_rx_lamp_out = lamp_ff[0];
  assign serial_tx_lamp_out = lamp_ff[1];
  assign can_rx_lamp_out    = lamp_ff[2];
  assign can_tx_lamp_out    = lamp_ff[3];

  property p_stop_test;
    @(posedge clk_in) disable iff (rst_in)
    rx_valid_in && rx_data_in == CH_Z |=> bridge_ff;
  endproperty
  a_stop_test: assert property (p_stop_test)
    else $error("z did not enter bridge mode");
  property p_start_i;
    @(posedge clk_in) disable iff (rst_in)
    bridge_ff && rx_valid_in && ps_ff == PS_IDLE && rx_data_in == CH_I
    |=> ps_ff == PS_ID ##0 cnt_ff == 5'h00;
  endproperty
  a_start_i: assert property (p_start_i)
    else $error("i did not start a command");
  property p_launch;
    @(posedge clk_in) disable iff (rst_in)
    z_ok && !ctv_ff |=> ctv_ff && can_tx_id_out == $past(id_ff[10:0]);
  endproperty
  a_launch: assert property (p_launch)
    else $error("z did not launch the frame");
  property p_dlc;
    @(posedge clk_in) disable iff (rst_in)
    z_ok && !ctv_ff |=> can_tx_dlc_out == $past(cnt_ff[4:1]);
  endproperty
  a_dlc: assert property (p_dlc)
    else $error("length code is not the pair count");
  property p_syntax;
    @(posedge clk_in) disable iff (rst_in)
    bridge_ff && rx_valid_in && ps_ff == PS_ID && !is_hex
    |=> ps_ff == PS_IDLE ##1 !$rose(ctv_ff);
  endproperty
  a_syntax: assert property (p_syntax)
    else $error("bad character did not discard command");
  property p_rx_lamp;
    @(posedge clk_in) disable iff (rst_in)
    rx_valid_in |=> serial_rx_lamp_out;
  endproperty
  a_rx_lamp: assert property (p_rx_lamp)
    else $error("serial receive lamp off");
  property p_tx_lamp;
    @(posedge clk_in) disable iff (rst_in)
    tx_valid_out && tx_ready_in |=> serial_tx_lamp_out;
  endproperty
  a_tx_lamp: assert property (p_tx_lamp)
    else $error("serial transmit lamp off");
  property p_can_lamps;
    @(posedge clk_in) disable iff (rst_in)
    can_rx_valid_in |=> can_rx_lamp_out;
  endproperty
  a_can_lamps: assert property (p_can_lamps)
    else $error("CAN receive lamp off");
  property p_can_tx_lamp;
    @(posedge clk_in) disable iff (rst_in)
    can_tx_done_in |=> can_tx_lamp_out;
  endproperty
  a_can_tx_lamp: assert property (p_can_tx_lamp)
    else $error("CAN transmit lamp off");
  property p_err;
    @(posedge clk_in) disable iff (rst_in)
    can_error_in |=> &lamp_ff;
  endproperty
  a_err: assert property (p_err)
    else $error("error did not light all lamps");
  property p_ovf;
    @(posedge clk_in) disable iff (rst_in)
    can_rx_valid_in && full |=> ovf_ff || fm_warn_ff;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow not flagged");
endmodule
`default_nettype wire

// file: rtl/ucb_pkg.sv
// Constants and types for the serial-to-CAN command bridge.
// Assumes byte-level UART and frame-level CAN controller ports.
package ucb_pkg;
  localparam int          UART_DATA_BITS  = 8;
  localparam int          UART_STOP_BITS  = 1;
  localparam int          CAN_BITRATE_BPS = 500000;
  localparam int          RX_FIFO_DEPTH   = 4;
  localparam int          LAMP_HOLD       = 8;
  localparam int          MAX_BYTES       = 8;
  localparam logic [7:0]  CH_I            = 8'h69;
  localparam logic [7:0]  CH_D            = 8'h64;
  localparam logic [7:0]  CH_Z            = 8'h7a;
  localparam logic [7:0]  TEST_FIRST      = 8'h30;
  localparam logic [7:0]  TEST_LAST       = 8'h7a;
  localparam logic [7:0]  CH_CR           = 8'h0d;
  localparam logic [7:0]  CH_LF           = 8'h0a;
  localparam logic [4:0]  ID_LAST_DIGIT   = 5'h02;
  localparam logic [4:0]  DATA_START      = 5'h0c;
  localparam logic [4:0]  WARN_LAST       = 5'h04;
  typedef enum logic [1:0] {
    PS_IDLE   = 2'b00,
    PS_ID     = 2'b01,
    PS_WAIT_D = 2'b10,
    PS_DATA   = 2'b11
  } ucb_pstate_t;
endpackage

// file: dv/ucb_partner.sv
// Far-side model: serial terminal and CAN controller.
// Assumes byte and frame handshakes sampled on the rising clk edge.
`timescale 1ns/1ps
`default_nettype none
module ucb_partner (
  // Clock and stall controls
  input  wire logic        clk_in,
  input  wire logic        uart_stall_in,
  input  wire logic        can_stall_in,
  // Serial bytes from the bridge
  input  wire logic        tx_valid_in,
  input  wire logic [7:0]  tx_data_in,
  output logic             tx_ready_out,
  // CAN frames from the bridge
  input  wire logic        can_tx_valid_in,
  input  wire logic [10:0] can_tx_id_in,
  input  wire logic [3:0]  can_tx_dlc_in,
  input  wire logic [63:0] can_tx_data_in,
  output logic             can_tx_ready_out,
  output logic             can_tx_done_out
);
  logic [7:0]  rxq[$];
  logic [10:0] fr_id;
  logic [3:0]  fr_dlc;
  logic [63:0] fr_data;
  int          fr_cnt = 0;
  int          done_cnt = 0;
  logic        done_ff = 1'b0;
  // Whole 8-bit bytes, no flow control beyond a plain stall
  assign tx_ready_out     = ~uart_stall_in;
  assign can_tx_ready_out = ~can_stall_in;
  assign can_tx_done_out  = done_ff;
  always @(posedge clk_in) begin
    if (tx_valid_in && tx_ready_out)
      rxq.push_back(tx_data_in);
  end
  // Bus confirms a frame three cycles after taking it
  always @(posedge clk_in) begin
    done_ff <= (done_cnt == 1);
    if (done_cnt != 0)
      done_cnt <= done_cnt - 1;
    if (can_tx_valid_in && can_tx_ready_out) begin
      fr_id    <= can_tx_id_in;
      fr_dlc   <= can_tx_dlc_in;
      fr_data  <= can_tx_data_in;
      fr_cnt   <= fr_cnt + 1;
      done_cnt <= 3;
    end
  end
endmodule
`default_nettype wire

// file: dv/ucb_bridge_tb_top.sv
// Self-checking bench for the serial-to-CAN command bridge.
// Assumes ucb_partner as terminal and CAN controller model.
`timescale 1ns/1ps
`default_nettype none
module ucb_bridge_tb_top;
  import ucb_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        rx_v = 1'b0;
  logic [7:0]  rx_d = 8'h00;
  logic        ustall = 1'b0;
  logic        cstall = 1'b0;
  logic        crv = 1'b0;
  logic [10:0] crid = 11'h000;
  logic [3:0]  crdlc = 4'h0;
  logic [63:0] crdata = 64'h0;
  logic        cerr = 1'b0;
  logic        tx_rdy, tx_v, ctr, cdone, ctv, mode;
  logic [7:0]  tx_d;
  logic [10:0] cid;
  logic [3:0]  cdlc;
  logic [63:0] cdata;
  logic [19:0] rate;
  logic [3:0]  lamps;
  int          fails = 0;
  int          checks = 0;

  ucb_bridge dut (.clk_in(clk), .rst_in(rst), .rx_valid_in(rx_v),
    .rx_data_in(rx_d), .tx_ready_in(tx_rdy), .tx_valid_out(tx_v),
    .tx_data_out(tx_d), .can_tx_ready_in(ctr), .can_tx_done_in(cdone),
    .can_tx_valid_out(ctv), .can_tx_id_out(cid), .can_tx_dlc_out(cdlc),
    .can_tx_data_out(cdata), .can_rx_valid_in(crv), .can_rx_id_in(crid),
    .can_rx_dlc_in(crdlc), .can_rx_data_in(crdata), .can_error_in(cerr),
    .can_bitrate_out(rate), .bridge_mode_out(mode),
    .serial_rx_lamp_out(lamps[0]), .serial_tx_lamp_out(lamps[1]),
    .can_rx_lamp_out(lamps[2]), .can_tx_lamp_out(lamps[3]));
  ucb_partner p (.clk_in(clk), .uart_stall_in(ustall),
    .can_stall_in(cstall), .tx_valid_in(tx_v), .tx_data_in(tx_d),
    .tx_ready_out(tx_rdy), .can_tx_valid_in(ctv), .can_tx_id_in(cid),
    .can_tx_dlc_in(cdlc), .can_tx_data_in(cdata),
    .can_tx_ready_out(ctr), .can_tx_done_out(cdone));

  initial forever #50 clk = ~clk;

  task automatic chk(input string nm, input logic [63:0] got,
                     input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic waitn(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Terminal sends one byte per cycle; line shows inverse when idle
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      rx_v = 1'b1;
      rx_d = s[i];
      @(negedge clk);
    end
    rx_v = 1'b0;
    rx_d = ~rx_d;
  endtask

  task automatic cmd(input string s, input logic [10:0] id,
                     input logic [3:0] dlc, input logic [63:0] d);
    int n0;
    n0 = p.fr_cnt;
    send(s);
    for (int i = 0; i < 50 && p.fr_cnt == n0; i++)
      waitn(1);
    chk("frame count", p.fr_cnt, n0 + 1);
    chk("frame id", p.fr_id, id);
    chk("frame dlc", p.fr_dlc, dlc);
    chk("frame data", p.fr_data, d);
  endtask

  task automatic nocmd(input string s);
    int n0;
    n0 = p.fr_cnt;
    send(s);
    waitn(20);
    chk("no frame", p.fr_cnt, n0);
  endtask

  task automatic canrx(input logic [10:0] id, input logic [3:0] dlc,
                       input logic [63:0] d);
    crv = 1'b1;
    crid = id;
    crdlc = dlc;
    crdata = d;
    @(negedge clk);
    crv = 1'b0;
    crid = ~crid;
    crdlc = ~crdlc;
    crdata = ~crdata;
  endtask

  task automatic t_reset;
    waitn(4);
    chk("bitrate", rate, 20'h7a120);
    chk("mode", mode, 1'b0);
    chk("stream first", p.rxq[0], 8'h30);
    chk("stream next", p.rxq[1], 8'h31);
    chk("tx lamp", lamps[1], 1'b1);
  endtask

  task automatic t_enter;
    send("z");
    waitn(1);
    chk("rx lamp", lamps[0], 1'b1);
    chk("mode", mode, 1'b1);
    waitn(5);
    p.rxq.delete();
    waitn(30);
    chk("stream stopped", p.rxq.size(), 0);
  endtask

  task automatic t_cmd;
    int n0;
    n0 = p.fr_cnt;
    cstall = 1'b1;
    send("i7A0d0102z");
    chk("frame pending", ctv, 1'b1);
    waitn(5);
    chk("frame held", ctv, 1'b1);
    cstall = 1'b0;
    waitn(2);
    chk("frame taken", p.fr_cnt, n0 + 1);
    chk("frame id", p.fr_id, 11'h7a0);
    chk("frame dlc", p.fr_dlc, 4'h2);
    chk("frame data", p.fr_data, 64'h0102_0000_0000_0000);
    waitn(4);
    chk("can tx lamp", lamps[3], 1'b1);
    cmd("i123dz", 11'h123, 4'h0, 64'h0);
    cmd("iFFFd0102030405060708z", 11'h7ff, 4'h8, 64'h0102030405060708);
    cmd("i0ABdC5Dz", 11'h0ab, 4'h1, 64'hc500_0000_0000_0000);
    // Lowercase hex is not a digit
    nocmd("i7a0d01z");
    nocmd("i12Gd01z");
    nocmd("i123x01z");
    nocmd("i123d010203040506070809z");
    nocmd("d01z");
    cmd("i456dFFz", 11'h456, 4'h1, 64'hff00_0000_0000_0000);
  endtask

  task automatic t_report;
    string exp;
    exp = "ID=501 Data=00540000\015\012";
    p.rxq.delete();
    canrx(11'h501, 4'h4, 64'h0054_0000_0000_0000);
    waitn(1);
    chk("can rx lamp", lamps[2], 1'b1);
    for (int i = 0; i < 300 && p.rxq.size() < exp.len(); i++)
      waitn(1);
    chk("report length", p.rxq.size(), exp.len());
    for (int i = 0; i < exp.len(); i++)
      chk("report byte", p.rxq[i], exp[i]);
  endtask

  task automatic t_ovf;
    int ovf;
    int ids;
    ovf = 0;
    ids = 0;
    p.rxq.delete();
    ustall = 1'b1;
    // Gap cycle so the strobe never drops and rises in one step
    for (int i = 0; i < 7; i++) begin
      canrx(11'h010 + 11'(i), 4'h1, 64'h0);
      waitn(1);
    end
    waitn(10);
    ustall = 1'b0;
    waitn(400);
    for (int i = 0; i + 2 < p.rxq.size(); i++) begin
      if (p.rxq[i] == "O" && p.rxq[i+1] == "V" && p.rxq[i+2] == "F")
        ovf++;
      if (p.rxq[i] == "I" && p.rxq[i+1] == "D" && p.rxq[i+2] == "=")
        ids++;
    end
    chk("overflow warning", ovf, 1);
    // Full queue plus the line already taken by the formatter
    chk("queued lines", ids, RX_FIFO_DEPTH + 1);
  endtask

  task automatic t_err;
    waitn(30);
    chk("lamps quiet", lamps, 4'h0);
    cerr = 1'b1;
    waitn(2);
    chk("error lamps", lamps, 4'hf);
    cerr = 1'b0;
    waitn(12);
    chk("lamps after error", lamps, 4'h0);
  endtask

  // Whole run is about 800 cycles; allow 25 times that
  initial begin
    #(20000 * 100);
    fails++;
    test_done();
  end

  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_enter();
    t_cmd();
    t_report();
    t_ovf();
    t_err();
    test_done();
  end
endmodule
`default_nettype wire
